/* File: pkg/sdd_pkg.sv */
// Purpose: Shared constants, states and helpers of the stereo decimator.
// Assumes: 25 MHz system clock, one-bit streams at 128 times the frame rate.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package sdd_pkg;
  // ----------------------------------------
  // Filter shape
  // ----------------------------------------
  localparam int SINC_RATIO = 64;
  localparam int HB_RATIO = 2;
  localparam int TOTAL_RATIO = SINC_RATIO * HB_RATIO;
  localparam int SINC_W = 20;
  localparam int SAMPLE_W = 16;
  localparam int HB_TAPS = 7;
  localparam int HB_ACC_W = 26;
  localparam int HB_SHIFT = 8;
  localparam logic signed [HB_ACC_W-1:0] HB_C_OUTER = 26'sh3FFFFFF;
  localparam logic signed [HB_ACC_W-1:0] HB_C_INNER = 26'sh0000009;
  localparam logic signed [HB_ACC_W-1:0] HB_C_CENTRE = 26'sh0000010;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 16'sh7FFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 16'sh8000;
  // ----------------------------------------
  // Calibration and pins
  // ----------------------------------------
  localparam int CAL_SETTLE_FRAMES = 4;
  localparam int CAL_LOG2 = 4;
  localparam int CAL_FRAMES = 1 << CAL_LOG2;
  localparam int CAL_CNT_W = 5;
  localparam int CAL_ACC_W = SAMPLE_W + CAL_LOG2;
  localparam int SYNC_PINS = 6;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OFFSET_L = 8'h08;
  localparam logic [7:0] ADDR_OFFSET_R = 8'h0C;
  localparam logic [7:0] ADDR_SAMPLE_L = 8'h10;
  localparam logic [7:0] ADDR_SAMPLE_R = 8'h14;
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_CAL_CHIP = 1;
  localparam int CTRL_CAL_SYS = 2;
  localparam int STAT_CAL_ACTIVE = 0;
  localparam int STAT_CAL_SYS = 1;
  localparam int STAT_STANDBY = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SDD_CAL_IDLE = 2'b00,
    SDD_CAL_SETTLE = 2'b01,
    SDD_CAL_MEASURE = 2'b10
  } sdd_cal_state_t;

  function automatic logic signed [SAMPLE_W-1:0] sdd_sat16(
      input logic signed [HB_ACC_W-1:0] v);
    logic signed [SAMPLE_W-1:0] r;
    if (v > HB_ACC_W'(SAMPLE_MAX)) begin
      r = SAMPLE_MAX;
    end else if (v < HB_ACC_W'(SAMPLE_MIN)) begin
      r = SAMPLE_MIN;
    end else begin
      r = v[SAMPLE_W-1:0];
    end
    return r;
  endfunction
endpackage

/* File: design/sdd_sinc3.sv */
// Purpose: Third-order comb decimator for one one-bit stream.
// Assumes: bitStrobe marks one new modulator bit per pulse.
// Notes: Integrators wrap on purpose; the combs undo the wrap.
`timescale 1ns/10ps
`default_nettype none
module sdd_sinc3 #(
  parameter int RATIO = sdd_pkg::SINC_RATIO,
  parameter int W = sdd_pkg::SINC_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic run,
  input wire logic align,
  input wire logic bitStrobe,
  input wire logic bitIn,
  output logic signed [W-1:0] sincOut,
  output logic sincValid
);
  localparam int CNT_W = $clog2(RATIO);
  localparam logic signed [W-1:0] PLUS_ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic signed [W-1:0] MINUS_ONE = {W{1'b1}};

  logic signed [W-1:0] integ1, integ2, integ3, dly1, dly2, dly3;
  logic [CNT_W-1:0] phase;
  wire logic signed [W-1:0] inVal = bitIn ? PLUS_ONE : MINUS_ONE;
  wire logic signed [W-1:0] comb1 = integ3 - dly1;
  wire logic signed [W-1:0] comb2 = comb1 - dly2;
  wire logic signed [W-1:0] comb3 = comb2 - dly3;
  wire logic take = run && bitStrobe;
  wire logic dump = take && (phase == CNT_W'(RATIO - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      integ1 <= '0;
      integ2 <= '0;
      integ3 <= '0;
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      phase <= '0;
      sincOut <= '0;
      sincValid <= 1'b0;
    end else begin
      sincValid <= dump;
      if (take) begin
        integ1 <= integ1 + inVal;
        integ2 <= integ2 + integ1;
        integ3 <= integ3 + integ2;
      end
      if (align) begin
        phase <= '0;
      end else if (take) begin
        phase <= phase + CNT_W'(1);
      end
      if (dump) begin
        dly1 <= integ3;
        dly2 <= comb1;
        dly3 <= comb2;
        sincOut <= comb3;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/sdd_halfband.sv */
// Purpose: Seven-tap half-band FIR decimating by two.
// Assumes: Taps -1 0 9 16 9 0 -1, gain 32, scaled to 16 bits.
// Notes: Zero taps cost nothing; only five terms are summed.
`timescale 1ns/10ps
`default_nettype none
module sdd_halfband #(
  parameter int IN_W = sdd_pkg::SINC_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic run,
  input wire logic align,
  input wire logic inValid,
  input wire logic signed [IN_W-1:0] inData,
  output logic signed [sdd_pkg::SAMPLE_W-1:0] outData,
  output logic outValid
);
  localparam int AW = sdd_pkg::HB_ACC_W;
  logic signed [IN_W-1:0] tap [0:sdd_pkg::HB_TAPS-1];
  logic phase;
  wire logic take = run && inValid;
  wire logic signed [AW-1:0] acc =
      sdd_pkg::HB_C_OUTER * AW'(tap[0]) +
      sdd_pkg::HB_C_INNER * AW'(tap[2]) +
      sdd_pkg::HB_C_CENTRE * AW'(tap[3]) +
      sdd_pkg::HB_C_INNER * AW'(tap[4]) +
      sdd_pkg::HB_C_OUTER * AW'(tap[6]);
  wire logic signed [AW-1:0] scaled = acc >>> sdd_pkg::HB_SHIFT;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < sdd_pkg::HB_TAPS; i++) begin
        tap[i] <= '0;
      end
      phase <= 1'b0;
    end else begin
      if (take) begin
        tap[0] <= inData;
        for (int i = 1; i < sdd_pkg::HB_TAPS; i++) begin
          tap[i] <= tap[i-1];
        end
      end
      if (align) begin
        phase <= 1'b0;
      end else if (take) begin
        phase <= ~phase;
      end
    end
  end

  // Output computed one cycle after every second input
  logic fire;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fire <= 1'b0;
      outValid <= 1'b0;
      outData <= '0;
    end else begin
      fire <= take && phase;
      outValid <= fire;
      if (fire) begin
        outData <= sdd_pkg::sdd_sat16(scaled);
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/sdd_decimator.sv */
// Purpose: Stereo one-bit to 16-bit decimator with offset calibration.
// Assumes: Modulator clock and bits arrive on pins, slower than clk_sys/4.
// Notes: Registers over AXI4-Lite; outputs hold during calibration.
`timescale 1ns/10ps
`default_nettype none
module sdd_decimator #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  // Modulator side pins
  input wire logic modClk,
  input wire logic modBitLeft,
  input wire logic modBitRight,
  input wire logic adc_frame_sync,
  input wire logic calChipReq,
  input wire logic calSystemReq,
  output logic analogShortToRef,
  output logic calActive,
  output logic [sdd_pkg::SAMPLE_W-1:0] left_sample_out,
  output logic [sdd_pkg::SAMPLE_W-1:0] right_sample_out,
  output logic sampleValid,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int SW = sdd_pkg::SAMPLE_W;
  localparam int NP = sdd_pkg::SYNC_PINS;
  localparam int PIN_CLK = 0;
  localparam int PIN_BL = 1;
  localparam int PIN_BR = 2;
  localparam int PIN_SYNC = 3;
  localparam int PIN_CCHIP = 4;
  localparam int PIN_CSYS = 5;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Only plain flops, so stopping modClk loses nothing
  logic [NP-1:0] pinMeta, pinSync, pinLast;
  wire logic [NP-1:0] pinRaw = {calSystemReq, calChipReq, adc_frame_sync,
                                modBitRight, modBitLeft, modClk};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinLast <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  wire logic [NP-1:0] pinRise = pinSync & ~pinLast;
  wire logic bitStrobe = pinRise[PIN_CLK];
  wire logic frameEdge = pinRise[PIN_SYNC];
  wire logic chipEdge = pinRise[PIN_CCHIP];
  wire logic sysEdge = pinRise[PIN_CSYS];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic standby;
  logic swCalChip;
  logic swCalSys;
  wire logic run = !standby;

  // ----------------------------------------
  // Filter chains
  // ----------------------------------------
  wire logic signed [sdd_pkg::SINC_W-1:0] sincL, sincR;
  wire logic sincValidL, sincValidR;
  wire logic signed [SW-1:0] rawL, rawR;
  wire logic hbValidL, hbValidR;

  sdd_sinc3 u_sinc_left (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(run),
    .align(frameEdge),
    .bitStrobe(bitStrobe),
    .bitIn(pinSync[PIN_BL]),
    .sincOut(sincL),
    .sincValid(sincValidL)
  );

  sdd_sinc3 u_sinc_right (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(run),
    .align(frameEdge),
    .bitStrobe(bitStrobe),
    .bitIn(pinSync[PIN_BR]),
    .sincOut(sincR),
    .sincValid(sincValidR)
  );

  sdd_halfband u_hb_left (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(run),
    .align(frameEdge),
    .inValid(sincValidL),
    .inData(sincL),
    .outData(rawL),
    .outValid(hbValidL)
  );

  sdd_halfband u_hb_right (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .run(run),
    .align(frameEdge),
    .inValid(sincValidR),
    .inData(sincR),
    .outData(rawR),
    .outValid(hbValidR)
  );

  // ----------------------------------------
  // Calibration sequencer
  // ----------------------------------------
  sdd_pkg::sdd_cal_state_t calState, next_calState;
  logic calSystem;
  logic [sdd_pkg::CAL_CNT_W-1:0] calCount;
  logic signed [sdd_pkg::CAL_ACC_W-1:0] accL, accR;
  logic signed [SW-1:0] offsetL, offsetR;

  wire logic calStart = run && (chipEdge || sysEdge || swCalChip || swCalSys);
  wire logic calPickSys = sysEdge || swCalSys;
  wire logic frameDone = hbValidL;
  wire logic settleEnd =
      calCount == sdd_pkg::CAL_CNT_W'(sdd_pkg::CAL_SETTLE_FRAMES - 1);
  wire logic measureEnd =
      calCount == sdd_pkg::CAL_CNT_W'(sdd_pkg::CAL_FRAMES - 1);
  wire logic signed [sdd_pkg::CAL_ACC_W-1:0] sumL =
      accL + sdd_pkg::CAL_ACC_W'(rawL);
  wire logic signed [sdd_pkg::CAL_ACC_W-1:0] sumR =
      accR + sdd_pkg::CAL_ACC_W'(rawR);
  wire logic signed [sdd_pkg::CAL_ACC_W-1:0] avgL =
      sumL >>> sdd_pkg::CAL_LOG2;
  wire logic signed [sdd_pkg::CAL_ACC_W-1:0] avgR =
      sumR >>> sdd_pkg::CAL_LOG2;
  wire logic storeOffsets =
      (calState == sdd_pkg::SDD_CAL_MEASURE) && frameDone && measureEnd;

  always_comb begin
    next_calState = calState;
    case (calState)
      sdd_pkg::SDD_CAL_IDLE: begin
        if (calStart) begin
          next_calState = sdd_pkg::SDD_CAL_SETTLE;
        end
      end
      sdd_pkg::SDD_CAL_SETTLE: begin
        // Filter history still holds pre-calibration input
        if (frameDone && settleEnd) begin
          next_calState = sdd_pkg::SDD_CAL_MEASURE;
        end
      end
      sdd_pkg::SDD_CAL_MEASURE: begin
        if (storeOffsets) begin
          next_calState = sdd_pkg::SDD_CAL_IDLE;
        end
      end
      default: begin
        next_calState = sdd_pkg::SDD_CAL_IDLE;
      end
    endcase
  end

  wire logic countReset = (calState != next_calState);
  wire logic inCal = (calState != sdd_pkg::SDD_CAL_IDLE);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      calState <= sdd_pkg::SDD_CAL_IDLE;
      calSystem <= 1'b0;
      calCount <= '0;
    end else begin
      calState <= next_calState;
      if (calState == sdd_pkg::SDD_CAL_IDLE && calStart) begin
        calSystem <= calPickSys;
      end
      if (countReset) begin
        calCount <= '0;
      end else if (inCal && frameDone) begin
        calCount <= calCount + sdd_pkg::CAL_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      accL <= '0;
      accR <= '0;
      offsetL <= '0;
      offsetR <= '0;
    end else begin
      if (calState != sdd_pkg::SDD_CAL_MEASURE) begin
        accL <= '0;
        accR <= '0;
      end else if (frameDone) begin
        accL <= sumL;
        accR <= sumR;
      end
      if (storeOffsets) begin
        offsetL <= avgL[SW-1:0];
        offsetR <= avgR[SW-1:0];
      end
    end
  end

  // ----------------------------------------
  // Corrected outputs
  // ----------------------------------------
  wire logic signed [sdd_pkg::HB_ACC_W-1:0] diffL =
      sdd_pkg::HB_ACC_W'(rawL) - sdd_pkg::HB_ACC_W'(offsetL);
  wire logic signed [sdd_pkg::HB_ACC_W-1:0] diffR =
      sdd_pkg::HB_ACC_W'(rawR) - sdd_pkg::HB_ACC_W'(offsetR);
  wire logic emit = frameDone && !inCal && run;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_sample_out <= '0;
      right_sample_out <= '0;
      sampleValid <= 1'b0;
      calActive <= 1'b0;
      analogShortToRef <= 1'b0;
    end else begin
      sampleValid <= emit;
      if (emit) begin
        left_sample_out <= sdd_pkg::sdd_sat16(diffL);
        right_sample_out <= sdd_pkg::sdd_sat16(diffR);
      end
      calActive <= (next_calState != sdd_pkg::SDD_CAL_IDLE);
      // System calibration leaves the conditioning path in circuit
      analogShortToRef <= (next_calState != sdd_pkg::SDD_CAL_IDLE) &&
          !((calState == sdd_pkg::SDD_CAL_IDLE) ? calPickSys : calSystem);
    end
  end

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic awTaken, wTaken;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  wire logic awFire = s_axi_awvalid && s_axi_awready;
  wire logic wFire = s_axi_wvalid && s_axi_wready;
  wire logic doWrite = awTaken && wTaken && !s_axi_bvalid;
  wire logic wrCtrl = doWrite && (wrAddr[7:0] == sdd_pkg::ADDR_CTRL);
  wire logic wrHit = wrAddr[7:0] == sdd_pkg::ADDR_CTRL;
  wire logic ctrlLane = wrCtrl && wrStrb[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sdd_pkg::RESP_OKAY;
      awTaken <= 1'b0;
      wTaken <= 1'b0;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end else begin
      if (awFire) begin
        s_axi_awready <= 1'b0;
        awTaken <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (wFire) begin
        s_axi_wready <= 1'b0;
        wTaken <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awTaken <= 1'b0;
        wTaken <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? sdd_pkg::RESP_OKAY : sdd_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Start bits self-clear: one write gives one calibration if idle and not setting standby
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      standby <= 1'b0;
      swCalChip <= 1'b0;
      swCalSys <= 1'b0;
    end else begin
      if (ctrlLane) begin
        standby <= wrData[sdd_pkg::CTRL_STANDBY];
      end
      swCalChip <= ctrlLane && wrData[sdd_pkg::CTRL_CAL_CHIP];
      swCalSys <= ctrlLane && wrData[sdd_pkg::CTRL_CAL_SYS] &&
                  !wrData[sdd_pkg::CTRL_CAL_CHIP];
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  wire logic arFire = s_axi_arvalid && s_axi_arready;
  wire logic [7:0] rdAddr = s_axi_araddr[7:0];
  wire logic [31:0] statusWord = {29'h0, standby, calSystem, inCal};
  wire logic rdHit = (rdAddr == sdd_pkg::ADDR_CTRL) ||
                     (rdAddr == sdd_pkg::ADDR_STATUS) ||
                     (rdAddr == sdd_pkg::ADDR_OFFSET_L) ||
                     (rdAddr == sdd_pkg::ADDR_OFFSET_R) ||
                     (rdAddr == sdd_pkg::ADDR_SAMPLE_L) ||
                     (rdAddr == sdd_pkg::ADDR_SAMPLE_R);
  wire logic [31:0] rdMux =
      (rdAddr == sdd_pkg::ADDR_CTRL) ? {31'h0, standby} :
      (rdAddr == sdd_pkg::ADDR_STATUS) ? statusWord :
      (rdAddr == sdd_pkg::ADDR_OFFSET_L) ? {16'h0, offsetL} :
      (rdAddr == sdd_pkg::ADDR_OFFSET_R) ? {16'h0, offsetR} :
      (rdAddr == sdd_pkg::ADDR_SAMPLE_L) ? {16'h0, left_sample_out} :
      (rdAddr == sdd_pkg::ADDR_SAMPLE_R) ? {16'h0, right_sample_out} :
      32'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sdd_pkg::RESP_OKAY;
    end else begin
      if (arFire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? sdd_pkg::RESP_OKAY : sdd_pkg::RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sdd_decimator_monitor.sv */
// Purpose: Port-level checks of the stereo decimator.
// Assumes: Constant-density test streams, modulator bit >= 4 clk_sys.
// Notes: Gap and calibration bounds are in clk_sys cycles.
`timescale 1ns/10ps
`default_nettype none
module sdd_decimator_monitor (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic calActive,
  input wire logic analogShortToRef,
  input wire logic sampleValid,
  input wire logic [sdd_pkg::SAMPLE_W-1:0] left_sample_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // ----
  // Helper counters
  // ----
  // 128 bits of at least 4 cycles each
  localparam int GAP_MIN = 500;
  localparam int CAL_MIN = 9000;
  // Slowest frame rate still ends well inside this
  localparam int CAL_MAX = 1100000;
  logic [15:0] gap;
  logic seen;
  logic [20:0] calCnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 16'h0000;
      seen <= 1'b0;
      calCnt <= 21'h000000;
    end else begin
      seen <= seen | sampleValid;
      gap <= sampleValid ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
      calCnt <= calActive ? calCnt + 21'h000001 : 21'h000000;
    end
  end
  // ----
  // Assertions
  // ----
  valid_pulse_a: assert property (sampleValid |=> !sampleValid)
    else $error("sample valid longer than one cycle");
  valid_gap_a: assert property (
    sampleValid && seen |-> gap >= 16'(GAP_MIN))
    else $error("samples closer than one frame");
  cal_quiet_a: assert property (
    calActive && $past(calActive) |-> !sampleValid)
    else $error("sample issued during calibration");
  short_chip_a: assert property (
    $rose(analogShortToRef) |-> ##[0:1] calActive)
    else $error("reference tie outside calibration");
  out_hold_a: assert property (
    $changed(left_sample_out) |-> sampleValid)
    else $error("left sample changed without valid");
  cal_min_a: assert property (
    $fell(calActive) |-> calCnt >= 21'(CAL_MIN))
    else $error("calibration window too short");
  cal_max_a: assert property (
    calActive |-> calCnt < 21'(CAL_MAX))
    else $error("calibration never ends");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
bind sdd_decimator sdd_decimator_monitor mon (
  .clk_sys(clk_sys), .arst_n(arst_n), .calActive(calActive),
  .analogShortToRef(analogShortToRef), .sampleValid(sampleValid),
  .left_sample_out(left_sample_out), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp)
);
`default_nettype wire

/* File: tb/sdd_modulator_model.sv */
// Purpose: Stereo one-bit modulator stand-in with frame sync.
// Assumes: Bit clock is clk_sys/8, so the frame rate is about 24.4 kHz.
// Notes: Stream density comes from the two pattern inputs.
`timescale 1ns/10ps
`default_nettype none
module sdd_modulator_model (
  input wire logic clk_sys,
  input wire logic patLeft,
  input wire logic patRight,
  output logic modClk,
  output logic modBitLeft,
  output logic modBitRight,
  output logic frameSync
);
  logic [2:0] div;
  logic [6:0] bitIdx;
  initial begin
    div = 3'h0;
    bitIdx = 7'h00;
    modBitLeft = 1'b0;
    modBitRight = 1'b0;
  end
  // Bits move at the falling clock edge, four cycles from either rise
  always @(posedge clk_sys) begin
    div <= div + 3'h1;
    if (div == 3'h7) begin
      bitIdx <= bitIdx + 7'h01;
      modBitLeft <= patLeft;
      modBitRight <= patRight;
    end
  end
  assign modClk = div[2];
  assign frameSync = ~bitIdx[6];
endmodule
`default_nettype wire

/* File: tb/sdd_decimator_tb_top.sv */
// Purpose: Self-checking bench of the stereo decimator.
// Assumes: Modulator model at 128 bits per frame, full-scale patterns.
// Notes: Eight frames are allowed for the filters to settle.
`timescale 1ns/10ps
`default_nettype none
module sdd_decimator_tb_top;
  localparam int TMO = 95000;
  localparam logic [33:0] ROWS [3] = '{{2'b01, 16'h8000, 16'h7FFF},
    {2'b11, 16'h7FFF, 16'h7FFF}, {2'b10, 16'h7FFF, 16'h8000}};
  logic clk_sys, arst_n, modClk, mbl, mbr, fsync, patL, patR;
  logic chipReq, sysReq, shortRef, calActive, sampleValid;
  logic [15:0] left, right;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int error_cnt, compares, cyc, n;
  sdd_modulator_model part (.clk_sys(clk_sys), .patLeft(patL),
    .patRight(patR), .modClk(modClk), .modBitLeft(mbl),
    .modBitRight(mbr), .frameSync(fsync));
  sdd_decimator dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .modClk(modClk), .modBitLeft(mbl), .modBitRight(mbr),
    .adc_frame_sync(fsync), .calChipReq(chipReq),
    .calSystemReq(sysReq), .analogShortToRef(shortRef),
    .calActive(calActive), .left_sample_out(left),
    .right_sample_out(right), .sampleValid(sampleValid),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ----
  // Shared tasks
  // ----
  task automatic summarize();
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk_sys);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // One edge between transfers, so no signal is set twice at once
    @(posedge clk_sys);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // One edge between transfers, so no signal is set twice at once
    @(posedge clk_sys);
  endtask
  task automatic waitv(input int k);
    repeat (k) begin
      do @(posedge clk_sys); while (sampleValid !== 1'b1);
    end
  endtask
  task automatic runCal(input logic sys);
    chipReq <= ~sys;
    sysReq <= sys;
    repeat (8) @(posedge clk_sys);
    chipReq <= 1'b0;
    sysReq <= 1'b0;
    chk("ref tie", {31'h0, shortRef}, {31'h0, ~sys});
    axr(sdd_pkg::ADDR_STATUS, rd, rs);
    chk("cal status", rd, {30'h0, sys, 1'b1});
    while (calActive === 1'b1) @(posedge clk_sys);
    waitv(2);
    chk("left fixed", {16'h0, left}, 32'h0);
    chk("right fixed", {16'h0, right}, 32'h0);
    axr(sdd_pkg::ADDR_OFFSET_L, rd, rs);
    chk("offset left", rd, 32'h00007FFF);
    axr(sdd_pkg::ADDR_OFFSET_R, rd, rs);
    chk("offset right", rd, 32'h00008000);
  endtask
  // ----
  // Clock, timeout and sequence
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    {arst_n, patL, patR, chipReq, sysReq} = 5'b00000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hF};
    {error_cnt, compares, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (2) @(posedge clk_sys);
    chk("reset valid", {31'h0, sampleValid}, 32'h0);
    chk("reset left", {16'h0, left}, 32'h0);
    chk("reset awready", {31'h0, awready}, 32'h1);
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {patL, patR} <= ROWS[i][33:32];
      waitv(8);
      chk("left", {16'h0, left}, {16'h0, ROWS[i][31:16]});
      chk("right", {16'h0, right}, {16'h0, ROWS[i][15:0]});
    end
    axw(sdd_pkg::ADDR_STATUS, 32'h7, rs);
    chk("ro write", {30'h0, rs}, {30'h0, sdd_pkg::RESP_SLVERR});
    axr(8'h18, rd, rs);
    chk("unmapped resp", {30'h0, rs}, {30'h0, sdd_pkg::RESP_SLVERR});
    chk("unmapped data", rd, 32'h0);
    axw(sdd_pkg::ADDR_CTRL, 32'h1, rs);
    axr(sdd_pkg::ADDR_STATUS, rd, rs);
    chk("standby status", rd, 32'h4);
    n = 0;
    repeat (1500) begin
      @(posedge clk_sys);
      n += int'(sampleValid === 1'b1);
    end
    chk("standby quiet", n, 32'h0);
    axw(sdd_pkg::ADDR_CTRL, 32'h0, rs);
    // Frozen history needs a few frames before calibrating
    waitv(8);
    chk("resumed left", {16'h0, left}, 32'h00007FFF);
    axr(sdd_pkg::ADDR_SAMPLE_R, rd, rs);
    chk("sample reg", rd, 32'h00008000);
    runCal(1'b0);
    runCal(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
